// *** shared/osm_defines.vh ***
// Constants for the oscillator select and fail monitor block
`ifndef OSM_DEFINES_VH
`define OSM_DEFINES_VH

// Group codes
`define OSM_GRP_SLOW_XTAL 2'h0
`define OSM_GRP_FAST_RC 2'h1
`define OSM_GRP_SLOW_RC 2'h2
`define OSM_GRP_PRIMARY 2'h3

// Register indices and byte addresses
`define OSM_ADDR_W 4
`define OSM_ADDR_CTRL 4'h0
`define OSM_ADDR_STAT 4'h4

// Control register fields
`define OSM_CUR_HI 13
`define OSM_CUR_LO 12
`define OSM_REQ_HI 9
`define OSM_REQ_LO 8
`define OSM_LOCK_BIT 5
`define OSM_FAIL_BIT 3
`define OSM_SLOWX_BIT 1
`define OSM_SWREQ_BIT 0

// Status register fields
`define OSM_ST_SRC_RDY 0
`define OSM_ST_SLOWX_ON 1
`define OSM_ST_SLOWRC_ON 2
`define OSM_ST_SWITCHING 3

// Switch and monitor config
`define OSM_CFG_SW_MON 2'h0
`define OSM_CFG_SW_ONLY 2'h1

// Primary mode config: crystal modes without the PLL need start-up count
`define OSM_PM_XT 4'h4
`define OSM_PM_XTL_HI 3'h0
`define OSM_PM_HS_HI 3'h1
`define OSM_PM_PLL_MASK_XT 2'h1
`define OSM_PM_ECPLL4 4'hd
`define OSM_PM_ECPLL8 4'he
`define OSM_PM_ECPLL16 4'hf
`define OSM_PM_XTPLL4 4'h5
`define OSM_PM_XTPLL8 4'h6
`define OSM_PM_XTPLL16 4'h7

// Multiplier codes
`define OSM_MUL_NONE 2'h0
`define OSM_MUL_X4 2'h1
`define OSM_MUL_X8 2'h2
`define OSM_MUL_X16 2'h3

// Start-up counter
`define OSM_STARTUP_W 10
`define OSM_STARTUP_MAX 10'h3ff

// Glitch-free mux handshake depth
`define OSM_SYNC_W 2
`define OSM_ZERO16 16'h0000

`endif

// *** rtl/osm_startup_counter.v ***
// Crystal start-up counter: holds off a source until 1024 periods are seen
`timescale 1ns/1ps
module osm_startup_counter (
    input wire clk,
    input wire rstn,
    input wire restart,
    input wire needs_count,
    input wire osc_tick,
    output reg ready_r
);
`include "osm_defines.vh"

    reg [`OSM_STARTUP_W-1:0] cnt_r;
    reg [`OSM_STARTUP_W-1:0] cnt_nxt;
    reg ready_nxt;

    always @* begin
        cnt_nxt = cnt_r;
        ready_nxt = ready_r;
        if (restart) begin
            cnt_nxt = {`OSM_STARTUP_W{1'b0}};
            ready_nxt = !needs_count;
        end else if (!ready_r && osc_tick) begin
            if (cnt_r == `OSM_STARTUP_MAX)
                ready_nxt = 1'b1;
            else
                cnt_nxt = cnt_r + 1'b1;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= {`OSM_STARTUP_W{1'b0}};
            ready_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            ready_r <= ready_nxt;
        end
    end
endmodule // osm_startup_counter

// *** rtl/osm_source_enable.v ***
// Decides which slow oscillators run in each power mode
`timescale 1ns/1ps
module osm_source_enable (
    input wire clk,
    input wire rstn,
    input wire [1:0] cur_group,
    input wire slowx_en,
    input wire sleep_mode,
    input wire idle_mode,
    input wire monitor_on,
    input wire watchdog_on,
    input wire power_up_delay_timer_done,
    output reg slowx_on_r,
    output reg slowrc_on_r
);
`include "osm_defines.vh"

    reg slowx_nxt;
    reg slowrc_nxt;

    always @* begin
        if (sleep_mode)
            slowx_nxt = slowx_en;
        else if (idle_mode)
            slowx_nxt = (cur_group == `OSM_GRP_SLOW_XTAL) || slowx_en;
        else
            slowx_nxt = (cur_group == `OSM_GRP_SLOW_XTAL) || slowx_en;
        if (!power_up_delay_timer_done)
            slowrc_nxt = 1'b1;
        else if (monitor_on)
            slowrc_nxt = !sleep_mode;
        else
            slowrc_nxt = watchdog_on || (cur_group == `OSM_GRP_SLOW_RC);
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            slowx_on_r <= 1'b0;
            slowrc_on_r <= 1'b1;
        end else begin
            slowx_on_r <= slowx_nxt;
            slowrc_on_r <= slowrc_nxt;
        end
    end
endmodule // osm_source_enable

// *** rtl/osm_clock_control.v ***
// Oscillator group select, switching and fail-safe monitor control
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "osm_defines.vh"
module osm_clock_control (
    input wire clk,
    input wire rstn,
    input wire por_bor_event,
    input wire wake_event,
    input wire sleep_mode,
    input wire idle_mode,
    input wire power_up_delay_timer_done,
    input wire watchdog_on,
    input wire [1:0] switch_monitor_config,
    input wire [1:0] group_select_config,
    input wire [3:0] primary_mode_config,
    input wire primary_tick,
    input wire slowx_tick,
    input wire pll_lock_in,
    input wire osc_fail_detect,
    input wire [`OSM_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_r,
    output reg [1:0] sys_clk_sel_r,
    output reg sys_clk_gate_r,
    output reg [1:0] pll_mult_r,
    output reg clock_fail_trap_r,
    output reg slowx_on_r,
    output reg slowrc_on_r,
    output reg wdt_clk_slowrc_r
);

    // ==========================================================
    // Switch states
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_GATE = 2'h2;
    localparam ST_OPEN = 2'h3;

    // ==========================================================
    // Registers and decode nets
    reg [1:0] current_clock_group_r;
    reg [1:0] current_clock_group_nxt;
    reg [1:0] requested_clock_group_r;
    reg [1:0] requested_clock_group_nxt;
    reg slow_crystal_enable_r;
    reg slow_crystal_enable_nxt;
    reg switch_request_r;
    reg switch_request_nxt;
    reg clock_fail_flag_r;
    reg clock_fail_flag_nxt;
    reg lock_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] target_r;
    reg [1:0] target_nxt;
    reg [`OSM_SYNC_W-1:0] gate_cnt_r;
    reg [`OSM_SYNC_W-1:0] gate_cnt_nxt;
    reg gate_nxt;
    reg [1:0] sel_nxt;
    reg trap_nxt;
    reg [1:0] mult_nxt;
    reg [15:0] rdata_nxt;
    reg por_seen_r;

    wire switch_en;
    wire monitor_en;
    wire pri_count;
    wire pri_ready;
    wire slowx_ready;
    wire restart;
    wire pri_pll;
    wire target_stable;
    wire fail_now;
    wire wr_ctrl;
    wire slowx_on_w;
    wire slowrc_on_w;
    wire cur_unready;
    wire switching_w;

    // ==========================================================
    // Configuration decode
    assign switch_en = !switch_monitor_config[1];
    assign monitor_en = (switch_monitor_config == `OSM_CFG_SW_MON);
    assign restart = por_bor_event || wake_event;
    // Only crystal primary modes without the PLL need the start-up count
    assign pri_count = (primary_mode_config[3:1] == `OSM_PM_XTL_HI)
        || (primary_mode_config[3:1] == `OSM_PM_HS_HI)
        || (primary_mode_config == `OSM_PM_XT);
    assign pri_pll = (primary_mode_config == `OSM_PM_XTPLL4)
        || (primary_mode_config == `OSM_PM_XTPLL8)
        || (primary_mode_config == `OSM_PM_XTPLL16)
        || (primary_mode_config == `OSM_PM_ECPLL4)
        || (primary_mode_config == `OSM_PM_ECPLL8)
        || (primary_mode_config == `OSM_PM_ECPLL16);
    assign wr_ctrl = reg_wr && (reg_addr == `OSM_ADDR_CTRL);

    // ==========================================================
    // Start-up counters
    osm_startup_counter u_pri_cnt (
        .clk(clk),
        .rstn(rstn),
        .restart(restart),
        .needs_count(pri_count),
        .osc_tick(primary_tick),
        .ready_r(pri_ready)
    );

    osm_startup_counter u_slowx_cnt (
        .clk(clk),
        .rstn(rstn),
        .restart(restart),
        .needs_count(1'b1),
        .osc_tick(slowx_tick),
        .ready_r(slowx_ready)
    );

    // ==========================================================
    // Source enables
    osm_source_enable u_src_en (
        .clk(clk),
        .rstn(rstn),
        .cur_group(current_clock_group_r),
        .slowx_en(slow_crystal_enable_r),
        .sleep_mode(sleep_mode),
        .idle_mode(idle_mode),
        .monitor_on(monitor_en),
        .watchdog_on(watchdog_on),
        .power_up_delay_timer_done(power_up_delay_timer_done),
        .slowx_on_r(slowx_on_w),
        .slowrc_on_r(slowrc_on_w)
    );

    // ==========================================================
    // Source readiness and failure detection
    // Stable: counted and, if multiplied, locked
    assign target_stable = (target_r == `OSM_GRP_PRIMARY) ? (pri_ready && (!pri_pll || lock_r))
        : (target_r == `OSM_GRP_SLOW_XTAL) ? slowx_ready : 1'b1;

    // Only crystal-fed groups can still be starting; RC groups run at once
    assign cur_unready = (current_clock_group_r == `OSM_GRP_PRIMARY) ? !pri_ready
        : (current_clock_group_r == `OSM_GRP_SLOW_XTAL) ? !slowx_ready
        : 1'b0;

    // Late start after delay timer counts as a failure
    // Power-up only; a wake restarts the count but is not a late start
    assign fail_now = monitor_en && !sleep_mode
        && (osc_fail_detect || (power_up_delay_timer_done && !por_seen_r && cur_unready));

    // ==========================================================
    // Control and switch sequencing
    always @* begin
        current_clock_group_nxt = current_clock_group_r;
        requested_clock_group_nxt = requested_clock_group_r;
        slow_crystal_enable_nxt = slow_crystal_enable_r;
        switch_request_nxt = switch_request_r;
        clock_fail_flag_nxt = clock_fail_flag_r;
        state_nxt = state_r;
        target_nxt = target_r;
        gate_cnt_nxt = gate_cnt_r;
        gate_nxt = sys_clk_gate_r;
        sel_nxt = sys_clk_sel_r;
        trap_nxt = 1'b0;
        if (wr_ctrl) begin
            requested_clock_group_nxt = reg_wdata[`OSM_REQ_HI:`OSM_REQ_LO];
            slow_crystal_enable_nxt = reg_wdata[`OSM_SLOWX_BIT];
            // Request only rises while switching is allowed
            switch_request_nxt = reg_wdata[`OSM_SWREQ_BIT] && switch_en;
        end
        case (state_r)
            ST_IDLE: begin
                if (switch_request_r && switch_en) begin
                    target_nxt = requested_clock_group_r;
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // A source that never starts hangs here until software clears the request
                if (!switch_request_r)
                    state_nxt = ST_IDLE;
                else if (target_stable) begin
                    gate_nxt = 1'b0;
                    gate_cnt_nxt = {`OSM_SYNC_W{1'b0}};
                    state_nxt = ST_GATE;
                end
            end
            ST_GATE: begin
                // Clock held low for a few cycles before the mux moves
                gate_cnt_nxt = gate_cnt_r + 1'b1;
                if (&gate_cnt_r) begin
                    sel_nxt = target_r;
                    current_clock_group_nxt = target_r;
                    state_nxt = ST_OPEN;
                end
            end
            ST_OPEN: begin
                gate_nxt = 1'b1;
                switch_request_nxt = 1'b0;
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Fuses drive the mux directly; the current group only reports them
        if (!switch_en) begin
            current_clock_group_nxt = group_select_config;
            sel_nxt = group_select_config;
            gate_nxt = 1'b1;
            state_nxt = ST_IDLE;
        end
        // Failure wins over any switch in progress
        if (fail_now && current_clock_group_r != `OSM_GRP_FAST_RC) begin
            trap_nxt = 1'b1;
            current_clock_group_nxt = `OSM_GRP_FAST_RC;
            clock_fail_flag_nxt = 1'b1;
            switch_request_nxt = 1'b0;
            // Fallback uses the same gate hold as a switch, so no runt pulse
            target_nxt = `OSM_GRP_FAST_RC;
            gate_nxt = 1'b0;
            gate_cnt_nxt = {`OSM_SYNC_W{1'b0}};
            state_nxt = ST_GATE;
        end
        if (por_bor_event) begin
            current_clock_group_nxt = group_select_config;
            requested_clock_group_nxt = group_select_config;
            target_nxt = group_select_config;
            sel_nxt = group_select_config;
            switch_request_nxt = 1'b0;
            state_nxt = ST_IDLE;
            gate_nxt = 1'b1;
        end
    end

    // ==========================================================
    // Multiplier factor
    always @* begin
        case (primary_mode_config)
            `OSM_PM_XTPLL4, `OSM_PM_ECPLL4: mult_nxt = `OSM_MUL_X4;
            `OSM_PM_XTPLL8, `OSM_PM_ECPLL8: mult_nxt = `OSM_MUL_X8;
            `OSM_PM_XTPLL16, `OSM_PM_ECPLL16: mult_nxt = `OSM_MUL_X16;
            default: mult_nxt = `OSM_MUL_NONE;
        endcase
    end

    // ==========================================================
    // Register read
    assign switching_w = (state_r != ST_IDLE);

    always @* begin
        rdata_nxt = `OSM_ZERO16;
        if (reg_rd && reg_addr == `OSM_ADDR_CTRL) begin
            rdata_nxt[`OSM_CUR_HI:`OSM_CUR_LO] = current_clock_group_r;
            rdata_nxt[`OSM_REQ_HI:`OSM_REQ_LO] = requested_clock_group_r;
            rdata_nxt[`OSM_LOCK_BIT] = lock_r;
            rdata_nxt[`OSM_FAIL_BIT] = clock_fail_flag_r;
            rdata_nxt[`OSM_SLOWX_BIT] = slow_crystal_enable_r;
            rdata_nxt[`OSM_SWREQ_BIT] = switch_request_r;
        end else if (reg_rd && reg_addr == `OSM_ADDR_STAT) begin
            rdata_nxt[`OSM_ST_SRC_RDY] = target_stable;
            rdata_nxt[`OSM_ST_SLOWX_ON] = slowx_on_w;
            rdata_nxt[`OSM_ST_SLOWRC_ON] = slowrc_on_w;
            rdata_nxt[`OSM_ST_SWITCHING] = switching_w;
        end
    end

    // ==========================================================
    // State registers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            current_clock_group_r <= `OSM_GRP_FAST_RC;
            requested_clock_group_r <= `OSM_GRP_FAST_RC;
            slow_crystal_enable_r <= 1'b0;
            switch_request_r <= 1'b0;
            clock_fail_flag_r <= 1'b0;
            lock_r <= 1'b0;
            state_r <= ST_IDLE;
            target_r <= `OSM_GRP_FAST_RC;
            gate_cnt_r <= {`OSM_SYNC_W{1'b0}};
            sys_clk_gate_r <= 1'b1;
            sys_clk_sel_r <= `OSM_GRP_FAST_RC;
            clock_fail_trap_r <= 1'b0;
            pll_mult_r <= `OSM_MUL_NONE;
            reg_rdata_r <= `OSM_ZERO16;
            slowx_on_r <= 1'b0;
            slowrc_on_r <= 1'b1;
            wdt_clk_slowrc_r <= 1'b1;
            por_seen_r <= 1'b0;
        end else begin
            current_clock_group_r <= current_clock_group_nxt;
            requested_clock_group_r <= requested_clock_group_nxt;
            slow_crystal_enable_r <= slow_crystal_enable_nxt;
            switch_request_r <= switch_request_nxt;
            clock_fail_flag_r <= clock_fail_flag_nxt;
            lock_r <= pll_lock_in && pri_pll;
            state_r <= state_nxt;
            target_r <= target_nxt;
            gate_cnt_r <= gate_cnt_nxt;
            sys_clk_gate_r <= gate_nxt;
            sys_clk_sel_r <= sel_nxt;
            clock_fail_trap_r <= trap_nxt;
            pll_mult_r <= mult_nxt;
            reg_rdata_r <= rdata_nxt;
            slowx_on_r <= slowx_on_w;
            // Failure never stops the watchdog clock
            slowrc_on_r <= slowrc_on_w || watchdog_on;
            wdt_clk_slowrc_r <= 1'b1;
            // Late-start check fires once per power-up window
            if (por_bor_event)
                por_seen_r <= 1'b0;
            else if (power_up_delay_timer_done)
                por_seen_r <= 1'b1;
        end
    end
endmodule // osm_clock_control

// *** tb/osm_clock_control_checker.sv ***
// Port-level assertions for the oscillator select and fail monitor
`timescale 1ns/1ps
module osm_clock_control_checker (
    input wire clk,
    input wire rstn,
    input wire por_bor_event,
    input wire sleep_mode,
    input wire power_up_delay_timer_done,
    input wire watchdog_on,
    input wire [1:0] switch_monitor_config,
    input wire osc_fail_detect,
    input wire [1:0] sys_clk_sel_r,
    input wire sys_clk_gate_r,
    input wire clock_fail_trap_r,
    input wire slowx_on_r,
    input wire slowrc_on_r,
    input wire wdt_clk_slowrc_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire mon_run = (switch_monitor_config == 2'h0) && !sleep_mode;
    wire rc_idle = power_up_delay_timer_done && (switch_monitor_config != 2'h0) && !watchdog_on
        && (sys_clk_sel_r != 2'h2);
    // ==========================================
    // Checks
    chk_fail_to_fastrc: assert property (
        switch_monitor_config == 2'h0 && osc_fail_detect && !por_bor_event && !sleep_mode
        && sys_clk_sel_r != 2'h1 && sys_clk_gate_r
        |=> clock_fail_trap_r && !sys_clk_gate_r ##4 sys_clk_sel_r == 2'h1)
        else $error("no fallback");
    chk_trap_single: assert property (
        clock_fail_trap_r |=> !clock_fail_trap_r) else $error("trap too long");
    chk_monitor_off: assert property (
        switch_monitor_config != 2'h0 && $past(switch_monitor_config) != 2'h0
        |-> !clock_fail_trap_r) else $error("trap while monitor off");
    chk_gate_return: assert property (
        $fell(sys_clk_gate_r) |-> ##[1:8] sys_clk_gate_r) else $error("gate stuck low");
    // Source only moves while the clock is held, except forced loads
    chk_sel_gated: assert property (
        $changed(sys_clk_sel_r) && !$past(por_bor_event) && !$past(osc_fail_detect)
        && $past(power_up_delay_timer_done, 4) |-> !$past(sys_clk_gate_r)) else $error("ungated switch");
    chk_slowrc_early: assert property (
        !power_up_delay_timer_done && !$past(power_up_delay_timer_done) |-> slowrc_on_r) else $error("slow rc off early");
    chk_slowrc_mon: assert property (
        mon_run && $past(mon_run) && $past(mon_run, 2) |-> slowrc_on_r)
        else $error("slow rc off");
    chk_slowrc_idle: assert property (
        rc_idle && $past(rc_idle) && $past(rc_idle, 2) |-> !slowrc_on_r)
        else $error("slow rc left on");
    chk_slowx_cur: assert property (
        !sleep_mode && !$past(sleep_mode) && !$past(sleep_mode, 2) && sys_clk_sel_r == 2'h0
        && $past(sys_clk_sel_r) == 2'h0 && $past(sys_clk_sel_r, 2) == 2'h0
        |-> slowx_on_r) else $error("slow xtal off");
    chk_wdt_clock: assert property (
        1'b1 |-> wdt_clk_slowrc_r) else $error("watchdog clock lost");
    cov_trap: cover property (clock_fail_trap_r);
    cov_switch: cover property ($fell(sys_clk_gate_r));
    cov_slowx: cover property (sys_clk_sel_r == 2'h0 && slowx_on_r);
endmodule // osm_clock_control_checker

bind osm_clock_control osm_clock_control_checker osm_clock_control_checker_inst (
    .clk(clk), .rstn(rstn), .por_bor_event(por_bor_event), .sleep_mode(sleep_mode),
    .power_up_delay_timer_done(power_up_delay_timer_done), .watchdog_on(watchdog_on),
    .switch_monitor_config(switch_monitor_config), .osc_fail_detect(osc_fail_detect),
    .sys_clk_sel_r(sys_clk_sel_r), .sys_clk_gate_r(sys_clk_gate_r),
    .clock_fail_trap_r(clock_fail_trap_r), .slowx_on_r(slowx_on_r),
    .slowrc_on_r(slowrc_on_r), .wdt_clk_slowrc_r(wdt_clk_slowrc_r));

// *** tb/osm_partner.sv ***
// Crystal and external clock source model
`timescale 1ns/1ps
module osm_partner (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pri_dead,
    input wire logic slowx_on,
    input wire logic [1:0] pll_mult,
    output logic primary_tick,
    output logic slowx_tick,
    output logic pll_lock_in
);
    logic [3:0] lock_cnt_r;
    // ==========================================
    // Sources
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            primary_tick <= 1'b0;
            slowx_tick <= 1'b0;
            lock_cnt_r <= 4'h0;
            pll_lock_in <= 1'b0;
        end else begin
            // A dead crystal gives no periods at all
            primary_tick <= !pri_dead;
            slowx_tick <= slowx_on && !slowx_tick;
            if (pri_dead || pll_mult == 2'h0) begin
                lock_cnt_r <= 4'h0;
            end else if (lock_cnt_r != 4'hf) begin
                lock_cnt_r <= lock_cnt_r + 4'h1;
            end
            pll_lock_in <= (lock_cnt_r == 4'hf) && !pri_dead;
        end
    end
endmodule // osm_partner

// *** tb/osm_clock_control_tb.sv ***
// Self-checking bench for the oscillator select and fail monitor
`timescale 1ns/1ps
module osm_clock_control_tb;
    logic clk = 1'b0, rstn = 1'b0, por_bor_event = 1'b0, wake_event = 1'b0;
    logic sleep_mode = 1'b0, idle_mode = 1'b0, power_up_delay_timer_done = 1'b0, watchdog_on = 1'b0;
    logic osc_fail_detect = 1'b0, pri_dead = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0] switch_monitor_config = 2'h2, group_select_config = 2'h3;
    logic [3:0] primary_mode_config = 4'h4, reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, d;
    logic primary_tick, slowx_tick, pll_lock_in;
    wire [15:0] reg_rdata_r;
    wire [1:0] sys_clk_sel_r, pll_mult_r;
    wire sys_clk_gate_r, clock_fail_trap_r, slowx_on_r, slowrc_on_r, wdt_clk_slowrc_r;
    int num_errors = 0, compares = 0, cyc = 0, cur, req, fl, sxe, sw, n, traps;
    logic [3:0] modes [4] = '{4'h9, 4'h0, 4'h2, 4'h4};
    logic [3:0] pll_modes [6] = '{4'h5, 4'h6, 4'h7, 4'hd, 4'he, 4'hf};
    int grps [4] = '{2, 1, 3, 0};

    osm_clock_control osm_clock_control_inst (
        .clk(clk), .rstn(rstn), .por_bor_event(por_bor_event), .wake_event(wake_event),
        .sleep_mode(sleep_mode), .idle_mode(idle_mode), .power_up_delay_timer_done(power_up_delay_timer_done),
        .watchdog_on(watchdog_on), .switch_monitor_config(switch_monitor_config),
        .group_select_config(group_select_config), .primary_mode_config(primary_mode_config),
        .primary_tick(primary_tick), .slowx_tick(slowx_tick), .pll_lock_in(pll_lock_in),
        .osc_fail_detect(osc_fail_detect), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .sys_clk_sel_r(sys_clk_sel_r), .sys_clk_gate_r(sys_clk_gate_r),
        .pll_mult_r(pll_mult_r), .clock_fail_trap_r(clock_fail_trap_r),
        .slowx_on_r(slowx_on_r), .slowrc_on_r(slowrc_on_r),
        .wdt_clk_slowrc_r(wdt_clk_slowrc_r));
    osm_partner osm_partner_inst (.clk(clk), .rstn(rstn), .pri_dead(pri_dead),
        .slowx_on(slowx_on_r), .pll_mult(pll_mult_r), .primary_tick(primary_tick),
        .slowx_tick(slowx_tick), .pll_lock_in(pll_lock_in));

    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            results();
        end
    end
    // ==========================================
    // Model and bus tasks
    function automatic logic [15:0] ectl();
        return {2'b00, cur[1:0], 2'b00, req[1:0], 2'b00, pll_lock_in, 1'b0, fl[0], 1'b0,
            sxe[0], sw[0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata_r;
        @(posedge clk);
    endtask
    task automatic rdc();
        rd(4'h0, d);
        chk(d, ectl());
    endtask
    // Full reset plus power-on event; the primary counter finishes before the delay ends, the stopped slow crystal one does not
    task automatic por(input logic [1:0] g, input logic [3:0] m, input logic [1:0] k);
        rstn <= 1'b0;
        group_select_config <= g;
        primary_mode_config <= m;
        switch_monitor_config <= k;
        power_up_delay_timer_done <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        por_bor_event <= 1'b1;
        @(posedge clk);
        por_bor_event <= 1'b0;
        repeat (1100) @(posedge clk);
        power_up_delay_timer_done <= 1'b1;
        repeat (4) @(posedge clk);
        cur = g;
        req = g;
        fl = 0;
        sxe = 0;
        sw = 0;
    endtask
    task automatic results();
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    initial begin
        void'($urandom(32'h81d0_9afc));
        repeat (16) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            por(2'h3, modes[i], 2'h0);
            rdc();
            wake_event <= 1'b1;
            @(posedge clk);
            wake_event <= 1'b0;
            repeat (20) @(posedge clk);
            rd(4'h4, d);
            chk(d & 16'h0001, 16'(i == 0));
        end
        repeat (1100) @(posedge clk);
        rd(4'h4, d);
        chk(d & 16'h0001, 16'h0001);
        foreach (pll_modes[i]) begin
            por(2'h3, pll_modes[i], 2'h0);
            chk(pll_mult_r, pll_modes[i] & 4'h3);
            rdc();
            pri_dead <= 1'b1;
            repeat (3) @(posedge clk);
            rdc();
            pri_dead <= 1'b0;
        end
        // Slow crystal disabled, so this request hangs until aborted
        por(2'h3, 4'h4, 2'h1);
        req = 0;
        sw = 1;
        wr(4'h0, 16'h0001);
        repeat (30) @(posedge clk);
        rdc();
        sw = 0;
        wr(4'h0, 16'h0000);
        rdc();
        chk(slowx_on_r, 1'b0);
        sxe = 1;
        wr(4'h0, 16'h0002);
        repeat (2) @(posedge clk);
        chk(slowx_on_r, 1'b1);
        foreach (grps[i]) begin
            req = grps[i];
            wr(4'h0, {6'h00, req[1:0], 8'h03});
            for (n = 0; n < 3000 && sys_clk_sel_r !== req[1:0]; n++) @(posedge clk);
            repeat (4) @(posedge clk);
            cur = req;
            rdc();
            chk(sys_clk_sel_r, 16'(req));
        end
        sxe = 0;
        wr(4'h0, 16'h0000);
        for (n = 0; n < 3; n++) begin
            idle_mode <= (n == 1);
            sleep_mode <= (n == 2);
            repeat (4) @(posedge clk);
            chk(slowx_on_r, 16'(n != 2));
        end
        sxe = 1;
        wr(4'h0, 16'h0002);
        repeat (3) @(posedge clk);
        chk(slowx_on_r, 1'b1);
        sleep_mode <= 1'b0;
        repeat (4) begin
            wr(4'($urandom_range(15, 1)), 16'($urandom));
            rdc();
        end
        rd(4'h8, d);
        chk(d, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            watchdog_on <= (k == 3);
            por(2'h3, 4'h4, k[1:0]);
            chk(slowrc_on_r, 16'(k == 0 || k == 3));
            req = 0;
            sw = (k < 2);
            wr(4'h0, 16'h0001);
            repeat (3) @(posedge clk);
            osc_fail_detect <= 1'b1;
            @(posedge clk);
            osc_fail_detect <= 1'b0;
            traps = 0;
            repeat (4) begin
                #1 traps += clock_fail_trap_r;
                @(posedge clk);
            end
            chk(16'(traps), 16'(k == 0));
            if (k == 0) begin
                cur = 1;
                fl = 1;
                sw = 0;
            end
            rdc();
            chk(sys_clk_sel_r, 16'(cur));
            chk(wdt_clk_slowrc_r, 1'b1);
        end
        // Crystal never starts before the power-up delay runs out
        pri_dead <= 1'b1;
        por(2'h3, 4'h4, 2'h0);
        pri_dead <= 1'b0;
        cur = 1;
        fl = 1;
        rdc();
        results();
    end
endmodule // osm_clock_control_tb
